// ### wch_pkg.sv
package wch_pkg;

  // Sample width and buffer geometry.
  localparam int SMP_W = 13;
  localparam int DISP_LEN = 100;
  localparam int DISP_AW = 7;
  localparam int ANA_LEN = 1024;
  localparam int ANA_AW = 10;
  localparam int FIFO_DEPTH = 4;

  // Channel numbering: mains volts 0-5, mains currents 6-8, genset volts 9-14, genset currents 15-17.
  localparam int CH_W = 5;
  localparam logic [4:0] CH_LAST = 5'h11;
  localparam logic [4:0] CH_MI_FIRST = 5'h06;
  localparam logic [4:0] CH_MI_LAST = 5'h08;

  // One phase turn spans as many counts as there are samples per second.
  localparam int SAMPLE_RATE_SPS = 4096;
  localparam int PHASE_W = 12;
  localparam int FHZ_W = 11;

  // Harmonic limits and level scaling in tenths of a percent.
  localparam int MAX_ORDER = 31;
  localparam int MAX_HARM_HZ = 1800;
  localparam int LEVEL_W = 12;
  localparam int PERMILLE_FULL = 1000;
  localparam logic [11:0] GRAPH_MIN = 12'h014;
  localparam logic [11:0] LEVEL_SAT = 12'hfff;

  // Display vertical range in bits of magnitude.
  localparam int DISP_RANGE_BITS = 7;
  localparam int MAX_SHIFT = 6;

  // Refresh timing.
  localparam int CLK_HZ = 40000000;
  localparam int REFRESH_MS = 500;
  localparam int HALF_SEC_CYCLES = REFRESH_MS * (CLK_HZ / 1000);

  // Quarter-wave sine table, full scale 127, 16 steps per quarter turn.
  localparam logic [6:0] SIN_Q [17] = '{7'h00, 7'h0c, 7'h19, 7'h25, 7'h31, 7'h3c, 7'h47,
    7'h51, 7'h5a, 7'h62, 7'h6a, 7'h70, 7'h75, 7'h7a, 7'h7d, 7'h7e, 7'h7f};

  // One sample from the front end.
  typedef struct packed {
    logic valid;
    logic [SMP_W-1:0] data;
  } wch_smp_t;

  // One reported harmonic.
  typedef struct packed {
    logic valid;
    logic [4:0] order;
    logic [LEVEL_W-1:0] level;
    logic graph;
  } wch_harm_t;

endpackage

// ### wch_fifo.sv
`timescale 1ns/100ps
module wch_fifo #(
  parameter int W = 13,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Filling side.
  input wire logic [W-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  // Draining side.
  output logic [W-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);

  // Pointers, fill count and a registered ready.
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } wch_fifo_st_t;

  wch_fifo_st_t r, nxt;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;

  assign push = i_valid & r.rdy;
  assign pop = (r.cnt != '0) & i_ready;

  // Pointer and count update; ready drops as soon as the last slot is taken.
  always_comb
  begin
    nxt = r;
    if (push)
    begin
      nxt.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : AW'(r.wp + 1'b1);
    end
    if (pop)
    begin
      nxt.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : AW'(r.rp + 1'b1);
    end
    nxt.cnt = (AW + 1)'(r.cnt + push - pop);
    nxt.rdy = nxt.cnt != (AW + 1)'(DEPTH);
  end

  // State register; after reset the buffer is empty and ready.
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      r <= '0;
      r.rdy <= 1'b1;
    end
    else
    begin
      r <= nxt;
    end
  end

  // Storage has no reset; only written slots are ever read.
  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem[r.wp] <= i_data;
    end
  end

  assign o_ready = r.rdy;
  assign o_data = mem[r.rp];
  assign o_valid = r.cnt != '0;
endmodule

// ### wch_ram.sv
`timescale 1ns/100ps
module wch_ram #(
  parameter int DW = 13,
  parameter int AW = 8
) (
  // Clock.
  input wire logic i_clock,
  // Write port.
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // Read port, data one cycle after the address.
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];

  // Write and registered read.
  always_ff @(posedge i_clock)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// ### wch_analyzer.sv
`timescale 1ns/100ps
// Behaviour
// - Eighteen channels: volts and currents, mains and genset.
// - Mains currents only with load-side current transformers.
// - Display buffer: 100 samples, 13 bits, 4096/s.
// - Vertical scale chosen so waveform never clips.
// - Display buffer refreshed twice every second.
// - Display buffer readable over register read port.
// - Harmonic analysis of selected channel, twice per second.
// - Analysis buffer: 1024 samples, 13 bits, 4096/s.
// - Orders up to 31st and 1800 Hz.
// - Graph shows only harmonics above 2 percent.
// - Numeric levels given in 0.1 percent steps.
// - Buttons step through all available channels.
module wch_analyzer #(
  parameter int HALF_SEC_CYCLES = wch_pkg::HALF_SEC_CYCLES,
  parameter int FIFO_DEPTH = wch_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Sample stream from the front end for the selected channel.
  input wire wch_pkg::wch_smp_t i_smp,
  output logic o_smp_ready,
  // Configuration and measured fundamental, same clock domain.
  input wire logic i_ct_load_side,
  input wire logic [wch_pkg::FHZ_W-1:0] i_fund_hz,
  // Navigation buttons, asynchronous pins.
  input wire logic i_btn_next,
  input wire logic i_btn_prev,
  // Selected channel.
  output logic [wch_pkg::CH_W-1:0] o_channel,
  // Display buffer read port.
  input wire logic i_rd_en,
  input wire logic [wch_pkg::DISP_AW-1:0] i_rd_addr,
  output logic [wch_pkg::SMP_W-1:0] o_rd_data,
  output logic o_rd_valid,
  // Display scaling and refresh marker.
  output logic [2:0] o_scale_shift,
  output logic o_disp_fresh,
  // Harmonic results.
  output wch_pkg::wch_harm_t o_harm
);
  // Engine states.
  typedef enum logic [2:0] {E_IDLE, E_LOAD, E_ACC, E_MAG, E_DIV, E_EMIT} wch_eng_t;

  // Whole state of the block.
  typedef struct packed {
    logic [1:0] nxt_sync;
    logic [1:0] prv_sync;
    logic nxt_last;
    logic prv_last;
    logic [4:0] ch;
    logic [31:0] tick_cnt;
    logic tick;
    logic disp_arm;
    logic [6:0] disp_cnt;
    logic disp_wbank;
    logic disp_rbank;
    logic [12:0] peak;
    logic [2:0] scale;
    logic fresh;
    logic [10:0] ana_cnt;
    logic ana_wbank;
    logic ana_full;
    wch_eng_t eng;
    logic eng_bank;
    logic [10:0] fhz;
    logic [4:0] h;
    logic [10:0] n;
    logic rd_v;
    logic [11:0] phase;
    logic [11:0] phase_d;
    logic [11:0] step;
    logic signed [31:0] re;
    logic signed [31:0] im;
    logic [32:0] fund;
    logic [47:0] rem;
    logic [11:0] q;
    logic [3:0] bit_i;
    wch_pkg::wch_harm_t harm;
    logic rd_p1;
    logic rd_in;
    logic rd_v_o;
    logic [12:0] rd_data;
  } wch_st_t;

  wch_st_t r, nxt;
  logic [12:0] f_data;        // Sample at the FIFO head.
  logic f_vld;                // FIFO holds a sample.
  logic f_rdy;                // Capture logic wants a sample.
  logic fire;                 // A sample is taken this cycle.
  logic btn_n, btn_p;         // Button press pulses.
  logic chg;                  // Selected channel changes this cycle.
  logic [12:0] disp_q, ana_q; // Buffer read data.
  logic signed [20:0] p_cos, p_sin;

  // True for mains current channels.
  function automatic logic is_mi(input logic [4:0] c);
    return (c >= wch_pkg::CH_MI_FIRST) && (c <= wch_pkg::CH_MI_LAST);
  endfunction

  // Next available channel in either direction, with wrap-around.
  function automatic logic [4:0] step_ch(input logic [4:0] c0, input logic up, input logic ct);
    logic [4:0] c;
    logic done;
    c = c0;
    done = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (!done)
      begin
        if (up)
        begin
          c = (c == wch_pkg::CH_LAST) ? 5'h00 : 5'(c + 5'h01);
        end
        else
        begin
          c = (c == 5'h00) ? wch_pkg::CH_LAST : 5'(c - 5'h01);
        end
        done = ct | ~is_mi(c);
      end
    end
    return c;
  endfunction

  // Order lies within both limits; an unmeasured fundamental of zero never starts a run.
  function automatic logic in_limit(input logic [5:0] o, input logic [10:0] f);
    return (o != 6'h00) && (f != 11'h000) && (o <= 6'(wch_pkg::MAX_ORDER)) &&
      (17'(o) * 17'(f) <= 17'(wch_pkg::MAX_HARM_HZ));
  endfunction

  // Sine of a phase given in 64ths of a turn, full scale 127.
  function automatic logic signed [7:0] sin_of(input logic [5:0] p);
    logic [6:0] v;
    v = p[4] ? wch_pkg::SIN_Q[5'h10 - {1'b0, p[3:0]}] : wch_pkg::SIN_Q[p[3:0]];
    return p[5] ? -$signed({1'b0, v}) : $signed({1'b0, v});
  endfunction

  // Magnitude of a sample; the most negative value still fits unsigned.
  function automatic logic [12:0] abs13(input logic [12:0] x);
    return x[12] ? 13'(~x + 13'h001) : x;
  endfunction

  // Magnitude of an accumulator.
  function automatic logic [31:0] abs32(input logic signed [31:0] x);
    return x[31] ? 32'(~x + 32'h1) : 32'(x);
  endfunction

  // Approximate vector length: larger part plus half the smaller.
  function automatic logic [32:0] mag_of(input logic signed [31:0] a, input logic signed [31:0] b);
    logic [31:0] x, y;
    x = abs32(a);
    y = abs32(b);
    return (x > y) ? 33'(x) + 33'(y >> 1) : 33'(y) + 33'(x >> 1);
  endfunction

  // Smallest right shift that brings the peak inside the display range.
  function automatic logic [2:0] shift_for(input logic [12:0] pk);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 0; i < wch_pkg::MAX_SHIFT; i++)
    begin
      if ((pk >> s) >= (13'h001 << wch_pkg::DISP_RANGE_BITS))
      begin
        s = 3'(s + 3'h1);
      end
    end
    return s;
  endfunction

  // Small input buffer; once full, it stalls the front end while no capture wants data.
  wch_fifo #(.W(wch_pkg::SMP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock), .i_nrst(i_nrst),
    .i_data(i_smp.data), .i_valid(i_smp.valid), .o_ready(o_smp_ready),
    .o_data(f_data), .o_valid(f_vld), .i_ready(f_rdy)
  );

  // Two-bank display buffer: from the first commit on, one bank fills while readers see the other.
  wch_ram #(.DW(wch_pkg::SMP_W), .AW(wch_pkg::DISP_AW + 1)) u_disp (
    .i_clock(i_clock),
    .i_we(fire & r.disp_arm), .i_waddr({r.disp_wbank, r.disp_cnt}), .i_wdata(f_data),
    .i_raddr({r.disp_rbank, i_rd_addr}), .o_rdata(disp_q)
  );

  // Two-bank analysis buffer: one bank fills while the engine reads the other.
  wch_ram #(.DW(wch_pkg::SMP_W), .AW(wch_pkg::ANA_AW + 1)) u_ana (
    .i_clock(i_clock),
    .i_we(fire & ~r.ana_full), .i_waddr({r.ana_wbank, r.ana_cnt[9:0]}), .i_wdata(f_data),
    .i_raddr({r.eng_bank, r.n[9:0]}), .o_rdata(ana_q)
  );

  assign f_rdy = r.disp_arm | ~r.ana_full;
  assign fire = f_vld & f_rdy;
  assign btn_n = r.nxt_sync[1] & ~r.nxt_last;
  assign btn_p = r.prv_sync[1] & ~r.prv_last;
  assign chg = btn_n | btn_p | (~i_ct_load_side & is_mi(r.ch));
  assign p_cos = $signed(ana_q) * sin_of(6'(r.phase_d[11:6] + 6'h10));
  assign p_sin = $signed(ana_q) * sin_of(r.phase_d[11:6]);

  // Next-state logic for channel, captures, engine and read port.
  always_comb
  begin
    logic [12:0] pk;
    logic [47:0] pm;
    logic [47:0] sh;
    pk = '0;
    pm = '0;
    sh = '0;
    nxt = r;
    nxt.fresh = 1'b0;
    nxt.harm.valid = 1'b0;
    // Button synchronisers and edge memory.
    nxt.nxt_sync = {r.nxt_sync[0], i_btn_next};
    nxt.prv_sync = {r.prv_sync[0], i_btn_prev};
    nxt.nxt_last = r.nxt_sync[1];
    nxt.prv_last = r.prv_sync[1];
    // Half-second refresh tick.
    if (r.tick_cnt == 32'(HALF_SEC_CYCLES - 1))
    begin
      nxt.tick_cnt = '0;
      nxt.tick = 1'b1;
    end
    else
    begin
      nxt.tick_cnt = 32'(r.tick_cnt + 32'h1);
      nxt.tick = 1'b0;
    end
    // Display capture with peak tracking and an atomic commit.
    if (r.disp_arm && fire)
    begin
      pk = (abs13(f_data) > r.peak) ? abs13(f_data) : r.peak;
      nxt.peak = pk;
      nxt.disp_cnt = 7'(r.disp_cnt + 7'h01);
      if (r.disp_cnt == 7'(wch_pkg::DISP_LEN - 1))
      begin
        nxt.disp_arm = 1'b0;
        nxt.disp_rbank = r.disp_wbank;
        nxt.disp_wbank = ~r.disp_wbank;
        nxt.scale = shift_for(pk);
        nxt.fresh = 1'b1;
      end
    end
    if (r.tick)
    begin
      nxt.disp_arm = 1'b1;
      nxt.disp_cnt = '0;
      nxt.peak = '0;
    end
    // Analysis fill stops once the bank holds a full record.
    if (!r.ana_full && fire)
    begin
      nxt.ana_cnt = 11'(r.ana_cnt + 11'h001);
      nxt.ana_full = r.ana_cnt == 11'(wch_pkg::ANA_LEN - 1);
    end
    // Harmonic engine.
    case (r.eng)
      E_IDLE:
      begin
        if (r.tick && r.ana_full && in_limit(6'h01, i_fund_hz))
        begin
          nxt.eng_bank = r.ana_wbank;
          nxt.ana_wbank = ~r.ana_wbank;
          nxt.ana_full = 1'b0;
          nxt.ana_cnt = '0;
          nxt.fhz = i_fund_hz;
          nxt.h = 5'h01;
          nxt.eng = E_LOAD;
        end
      end
      E_LOAD:
      begin
        // Phase advance per sample equals order times frequency in turn/4096 units.
        nxt.step = 12'(16'(r.h) * 16'(r.fhz));
        nxt.phase = '0;
        nxt.n = '0;
        nxt.rd_v = 1'b0;
        nxt.re = '0;
        nxt.im = '0;
        nxt.eng = E_ACC;
      end
      E_ACC:
      begin
        nxt.rd_v = r.n != 11'(wch_pkg::ANA_LEN);
        if (r.n != 11'(wch_pkg::ANA_LEN))
        begin
          nxt.n = 11'(r.n + 11'h001);
          nxt.phase = 12'(r.phase + r.step);
          nxt.phase_d = r.phase;
        end
        if (r.rd_v)
        begin
          nxt.re = 32'(r.re + 32'(p_cos));
          nxt.im = 32'(r.im + 32'(p_sin));
        end
        if (r.n == 11'(wch_pkg::ANA_LEN) && !r.rd_v)
        begin
          nxt.eng = E_MAG;
        end
      end
      E_MAG:
      begin
        if (r.h == 5'h01)
        begin
          // The fundamental of this run is the reference for all orders.
          nxt.fund = mag_of(r.re, r.im);
          nxt.q = 12'(wch_pkg::PERMILLE_FULL);
          nxt.eng = (mag_of(r.re, r.im) == '0) ? E_IDLE : E_EMIT;
        end
        else
        begin
          pm = 48'(mag_of(r.re, r.im)) * 48'(wch_pkg::PERMILLE_FULL);
          nxt.rem = pm;
          nxt.q = '0;
          nxt.bit_i = 4'(wch_pkg::LEVEL_W - 1);
          if (pm >= (48'(r.fund) << wch_pkg::LEVEL_W))
          begin
            nxt.q = wch_pkg::LEVEL_SAT;
            nxt.eng = E_EMIT;
          end
          else
          begin
            nxt.eng = E_DIV;
          end
        end
      end
      E_DIV:
      begin
        // One quotient bit per cycle, in tenths of a percent.
        sh = 48'(r.fund) << r.bit_i;
        if (r.rem >= sh)
        begin
          nxt.rem = 48'(r.rem - sh);
          nxt.q[r.bit_i] = 1'b1;
        end
        nxt.bit_i = 4'(r.bit_i - 4'h1);
        nxt.eng = (r.bit_i == 4'h0) ? E_EMIT : E_DIV;
      end
      E_EMIT:
      begin
        nxt.harm.valid = 1'b1;
        nxt.harm.order = r.h;
        nxt.harm.level = r.q;
        nxt.harm.graph = r.q > wch_pkg::GRAPH_MIN;
        if (in_limit(6'({1'b0, r.h} + 6'h01), r.fhz))
        begin
          nxt.h = 5'(r.h + 5'h01);
          nxt.eng = E_LOAD;
        end
        else
        begin
          nxt.eng = E_IDLE;
        end
      end
      default:
      begin
        nxt.eng = E_IDLE;
      end
    endcase
    // Channel selection; a change restarts the analysis capture, cancels the display capture until the next tick and drops the run.
    if (chg)
    begin
      nxt.ch = step_ch(r.ch, ~btn_p | btn_n, i_ct_load_side);
      nxt.disp_arm = 1'b0;
      nxt.ana_cnt = '0;
      nxt.ana_full = 1'b0;
      nxt.eng = E_IDLE;
    end
    // Display read port: answer two cycles after the request.
    nxt.rd_p1 = i_rd_en;
    nxt.rd_in = i_rd_addr < 7'(wch_pkg::DISP_LEN);
    nxt.rd_v_o = r.rd_p1;
    if (r.rd_p1)
    begin
      nxt.rd_data = r.rd_in ? disp_q : '0;
    end
  end

  // State register.
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      r <= '0;
    end
    else
    begin
      r <= nxt;
    end
  end

  assign o_channel = r.ch;
  assign o_rd_data = r.rd_data;
  assign o_rd_valid = r.rd_v_o;
  assign o_scale_shift = r.scale;
  assign o_disp_fresh = r.fresh;
  assign o_harm = r.harm;

  // The selected channel always names one of the eighteen inputs.
  AST_CH_RANGE: assert property (@(posedge i_clock) disable iff (!i_nrst)
    r.ch <= wch_pkg::CH_LAST) else $error("Channel index out of range.");
  // Without load-side transformers no mains current stays selected.
  AST_CT_EXCL: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !i_ct_load_side |=> !is_mi(r.ch)) else $error("Mains current selected.");
  // A next press moves the channel.
  AST_BTN_STEP: assert property (@(posedge i_clock) disable iff (!i_nrst)
    btn_n |=> r.ch != $past(r.ch)) else $error("Button press ignored.");
  // A commit follows the hundredth stored sample.
  AST_DISP_LEN: assert property (@(posedge i_clock) disable iff (!i_nrst)
    r.fresh |-> $past(r.disp_cnt) == 7'(wch_pkg::DISP_LEN - 1)) else $error("Bad display length.");
  // The chosen scale keeps the peak inside the display range.
  AST_NO_CLIP: assert property (@(posedge i_clock) disable iff (!i_nrst)
    r.fresh |-> (r.peak >> r.scale) < (13'h001 << wch_pkg::DISP_RANGE_BITS))
    else $error("Display would clip.");
  // Every tick without a channel change starts a new display capture.
  AST_REFRESH: assert property (@(posedge i_clock) disable iff (!i_nrst)
    r.tick && !chg |=> r.disp_arm) else $error("Refresh not started.");
  // A read is answered exactly two cycles later.
  AST_RD_LAT: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_rd_en |-> ##2 o_rd_valid) else $error("Read answer late.");
  // A channel change aborts the running analysis.
  AST_ONE_CH: assert property (@(posedge i_clock) disable iff (!i_nrst)
    chg |=> r.eng == E_IDLE) else $error("Analysis kept across channel change.");
  // Accumulation ends only after the whole record.
  AST_ACC_LEN: assert property (@(posedge i_clock) disable iff (!i_nrst)
    r.eng == E_ACC ##1 r.eng == E_MAG |-> $past(r.n) == 11'(wch_pkg::ANA_LEN))
    else $error("Short analysis record.");
  // Reported orders respect both limits.
  AST_ORDER_LIM: assert property (@(posedge i_clock) disable iff (!i_nrst)
    r.harm.valid |-> in_limit({1'b0, r.harm.order}, r.fhz)) else $error("Order over limit.");
  // The graph flag marks exactly the levels above two percent.
  AST_GRAPH: assert property (@(posedge i_clock) disable iff (!i_nrst)
    r.harm.valid |-> r.harm.graph == (r.harm.level > wch_pkg::GRAPH_MIN))
    else $error("Graph flag wrong.");
  // The fundamental reports full scale.
  AST_FUND: assert property (@(posedge i_clock) disable iff (!i_nrst)
    r.harm.valid && r.harm.order == 5'h01 |-> r.harm.level == 12'(wch_pkg::PERMILLE_FULL))
    else $error("Fundamental not full scale.");
  // The readable bank only changes at a commit.
  AST_ATOMIC: assert property (@(posedge i_clock) disable iff (!i_nrst)
    r.disp_rbank != $past(r.disp_rbank) |-> r.fresh) else $error("Bank swapped mid capture.");
endmodule

// ### wch_frontend_model.sv
`timescale 1ns/100ps
// Front-end model: offers one sample at a time and holds it until the analyzer takes it.
module wch_frontend_model (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Waveform and pacing choice.
  input wire logic i_sine,
  input wire logic i_gap,
  input wire logic [10:0] i_tone_hz,
  // Sample stream toward the analyzer.
  output wch_pkg::wch_smp_t o_smp,
  input wire logic i_ready
);
  // Index of the next sample to offer.
  int n;

  // A ramp shows order plainly; a tone gives a known spectrum.
  function automatic logic [12:0] wave(input int k);
    real ph;
    ph = 6.2831853 * real'(i_tone_hz) * real'(k) / real'(wch_pkg::SAMPLE_RATE_SPS);
    return i_sine ? 13'(int'(2000.0 * $sin(ph))) : 13'(k);
  endfunction

  // Hold while refused; with gaps an idle cycle with scrambled data follows each sample.
  always @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      n <= 0;
      o_smp <= '0;
    end
    else if (o_smp.valid && !i_ready)
      o_smp <= o_smp;
    else if (o_smp.valid && i_gap)
      o_smp <= '{valid: 1'b0, data: ~o_smp.data};
    else
    begin
      o_smp <= '{valid: 1'b1, data: wave(n)};
      n <= n + 1;
    end
  end
endmodule

// ### wch_analyzer_tb.sv
`timescale 1ns/100ps
// Compares one value with its expectation and counts the outcome.
`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module wch_analyzer_tb;
  // Short refresh interval keeps the run brief.
  localparam int HALF = 3000;
  // Stimulus, model controls and tallies.
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ct_load_side = 1'b1;
  logic [10:0] i_fund_hz = 11'h000;
  logic i_btn_next = 1'b0;
  logic i_btn_prev = 1'b0;
  logic i_rd_en = 1'b0;
  logic [6:0] i_rd_addr = 7'h00;
  logic sine = 1'b0;
  logic gap = 1'b0;
  int n_errors = 0;
  int n_compared = 0;
  // Analyzer outputs.
  wch_pkg::wch_smp_t smp;
  wch_pkg::wch_harm_t o_harm;
  logic o_smp_ready;
  logic [4:0] o_channel;
  logic [12:0] o_rd_data;
  logic o_rd_valid;
  logic [2:0] o_scale_shift;
  logic o_disp_fresh;

  // A 40 MHz clock.
  always #12.5 i_clock = ~i_clock;

  wch_frontend_model wch_frontend_model_inst (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_sine(sine), .i_gap(gap), .i_tone_hz(i_fund_hz), .o_smp(smp), .i_ready(o_smp_ready));

  wch_analyzer #(.HALF_SEC_CYCLES(HALF), .FIFO_DEPTH(wch_pkg::FIFO_DEPTH)) wch_analyzer_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_smp(smp), .o_smp_ready(o_smp_ready),
    .i_ct_load_side(i_ct_load_side), .i_fund_hz(i_fund_hz), .i_btn_next(i_btn_next),
    .i_btn_prev(i_btn_prev), .o_channel(o_channel), .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_scale_shift(o_scale_shift),
    .o_disp_fresh(o_disp_fresh), .o_harm(o_harm));

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Counts cycles until a harmonic or refresh pulse; running out ends the run.
  task automatic wait_ev(input logic harm, output int t);
    t = 0;
    while (t < 9000)
    begin
      @(posedge i_clock);
      #1;
      t++;
      if ((harm ? o_harm.valid : o_disp_fresh) === 1'b1)
        return;
    end
    n_errors++;
    tally_and_finish();
  endtask

  // One button press, held long enough for the synchronizer.
  task automatic press(input logic nxt);
    @(posedge i_clock);
    if (nxt)
      i_btn_next <= 1'b1;
    else
      i_btn_prev <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_btn_next <= 1'b0;
    i_btn_prev <= 1'b0;
    repeat (6) @(posedge i_clock);
  endtask

  // One read; the answer must come exactly two cycles after the request is taken.
  task automatic rd(input logic [6:0] a, output logic [12:0] d);
    @(posedge i_clock);
    i_rd_en <= 1'b1;
    i_rd_addr <= a;
    @(posedge i_clock);
    i_rd_en <= 1'b0;
    @(posedge i_clock);
    #1;
    `CHK("read valid", 1'b1, o_rd_valid)
    d = o_rd_data;
  endtask

  // Outputs during reset, then release.
  task automatic scn_reset();
    repeat (20) @(posedge i_clock);
    #1;
    `CHK("channel", 5'h00, o_channel)
    `CHK("ready", 1'b1, o_smp_ready)
    `CHK("fresh", 1'b0, o_disp_fresh)
    `CHK("harmonic valid", 1'b0, o_harm.valid)
    @(posedge i_clock);
    i_nrst <= 1'b1;
  endtask

  // Stepping with and without mains currents offered.
  task automatic scn_channels();
    i_ct_load_side <= 1'b0;
    repeat (6) press(1'b1);
    `CHK("channel", 5'h09, o_channel)
    press(1'b0);
    `CHK("channel", 5'h05, o_channel)
    i_ct_load_side <= 1'b1;
    for (int k = 6; k < 18; k++)
    begin
      press(1'b1);
      `CHK("channel", 5'(k), o_channel)
    end
    repeat (11) press(1'b0);
    `CHK("channel", 5'h06, o_channel)
    i_ct_load_side <= 1'b0;
    repeat (3) @(posedge i_clock);
    `CHK("channel", 5'h09, o_channel)
  endtask

  // Refresh interval, whole consecutive capture, scaling and the refused address.
  task automatic scn_display();
    logic [12:0] d [100];
    logic [12:0] x;
    int t, v, pk, s;
    gap <= 1'b1;
    pk = 0;
    s = 0;
    repeat (3) wait_ev(1'b0, t);
    `CHK("refresh interval", HALF, t)
    for (int a = 0; a < 100; a++)
    begin
      rd(7'(a), d[a]);
      `CHK("display sample", 13'(d[0] + 13'(a)), d[a])
      v = int'($signed(d[a]));
      if (v < 0)
        v = -v;
      if (v > pk)
        pk = v;
    end
    while ((pk >> s) >= 128)
      s++;
    `CHK("scale shift", 3'(s), o_scale_shift)
    rd(7'h64, x);
    `CHK("data beyond buffer", 13'h0000, x)
    `CHK("ready between captures", 1'b0, o_smp_ready)
  endtask

  // A tone at f must give exactly nexp orders, the first at full level.
  task automatic scn_harm(input logic [10:0] f, input int nexp);
    int t;
    i_fund_hz <= f;
    sine <= 1'b1;
    gap <= 1'b0;
    press(1'b1);
    wait_ev(1'b1, t);
    `CHK("first order", 5'h01, o_harm.order)
    `CHK("fundamental level", 12'h3e8, o_harm.level)
    `CHK("fundamental graph", 1'b1, o_harm.graph)
    for (int k = 2; k <= nexp; k++)
    begin
      wait_ev(1'b1, t);
      `CHK("order", 5'(k), o_harm.order)
      `CHK("graph", o_harm.level > 12'h014, o_harm.graph)
    end
    repeat (1200)
    begin
      @(posedge i_clock);
      #1;
      if (o_harm.valid === 1'b1)
        `CHK("order after last", 5'h01, o_harm.order)
    end
  endtask

  // Main sequence: 40 Hz stops at the order cap, 400 Hz at the frequency cap.
  initial
  begin
    scn_reset();
    scn_channels();
    scn_display();
    scn_harm(11'h028, 31);
    scn_harm(11'h190, 4);
    tally_and_finish();
  end
endmodule
